/* logic/mipe_defines.vh */
`ifndef MIPE_DEFINES_VH
`define MIPE_DEFINES_VH

// ---------------------------------------------------------------
// Vector geometry
// ---------------------------------------------------------------
`define MIPE_XLEN        64
`define MIPE_CAUSE_W     6
`define MIPE_STD_LAST    15
`define MIPE_PLAT_FIRST  16

// ---------------------------------------------------------------
// Standard cause bit positions
// ---------------------------------------------------------------
`define MIPE_SSI_BIT     6'h01
`define MIPE_MSI_BIT     6'h03
`define MIPE_STI_BIT     6'h05
`define MIPE_MTI_BIT     6'h07
`define MIPE_SEI_BIT     6'h09
`define MIPE_MEI_BIT     6'h0B
`define MIPE_LCOF_BIT    6'h0D

// ---------------------------------------------------------------
// CSR access operations
// ---------------------------------------------------------------
`define MIPE_OP_W        2
`define MIPE_OP_NONE     2'h0
`define MIPE_OP_WRITE    2'h1
`define MIPE_OP_SET      2'h2
`define MIPE_OP_CLEAR    2'h3

// ---------------------------------------------------------------
// CSR selectors
// ---------------------------------------------------------------
`define MIPE_SEL_W       2
`define MIPE_SEL_PEND    2'h0
`define MIPE_SEL_ENAB    2'h1
`define MIPE_SEL_SPEND   2'h2
`define MIPE_SEL_SENAB   2'h3

// ---------------------------------------------------------------
// Privilege encodings and reset values
// ---------------------------------------------------------------
`define MIPE_PRIV_W      2
`define MIPE_PRIV_M      2'h3
`define MIPE_RST_VEC     64'h0000000000000000
`define MIPE_RST_CAUSE   6'h00

`endif

/* logic/mipe_csr_op.v */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// CSR write / set / clear merge
// ---------------------------------------------------------------
`include "mipe_defines.vh"
module mipe_csr_op (
    // Access
    input  wire [`MIPE_OP_W-1:0] i_op,
    input  wire [`MIPE_XLEN-1:0] i_old,
    input  wire [`MIPE_XLEN-1:0] i_wdata,
    input  wire [`MIPE_XLEN-1:0] i_mask,
    // Result
    output reg  [`MIPE_XLEN-1:0] o_new
);
    reg [`MIPE_XLEN-1:0] merged;
    always @* begin
        case (i_op)
            `MIPE_OP_WRITE: merged = i_wdata;
            `MIPE_OP_SET:   merged = i_old | i_wdata;
            `MIPE_OP_CLEAR: merged = i_old & ~i_wdata;
            default:        merged = i_old;
        endcase
        // Only writable bits take the merged value
        o_new = (merged & i_mask) | (i_old & ~i_mask);
    end
endmodule

/* logic/mipe_prio.v */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Fixed priority cause select
// ---------------------------------------------------------------
`include "mipe_defines.vh"
module mipe_prio (
    // Qualified requests
    input  wire [`MIPE_XLEN-1:0]    i_req,
    // Winner
    output reg                      o_any,
    output reg  [`MIPE_CAUSE_W-1:0] o_cause
);
    integer k;
    always @* begin
        o_any   = 1'h0;
        o_cause = `MIPE_RST_CAUSE;
        // Platform causes rank highest, lowest index first
        for (k = `MIPE_XLEN - 1; k >= `MIPE_PLAT_FIRST; k = k - 1) begin
            if (i_req[k]) begin
                o_any   = 1'h1;
                o_cause = k[`MIPE_CAUSE_W-1:0];
            end
        end
        if (!o_any) begin
            o_any = 1'h1;
            if (i_req[`MIPE_MEI_BIT])
                o_cause = `MIPE_MEI_BIT;
            else if (i_req[`MIPE_MSI_BIT])
                o_cause = `MIPE_MSI_BIT;
            else if (i_req[`MIPE_MTI_BIT])
                o_cause = `MIPE_MTI_BIT;
            else if (i_req[`MIPE_SEI_BIT])
                o_cause = `MIPE_SEI_BIT;
            else if (i_req[`MIPE_SSI_BIT])
                o_cause = `MIPE_SSI_BIT;
            else if (i_req[`MIPE_STI_BIT])
                o_cause = `MIPE_STI_BIT;
            else if (i_req[`MIPE_LCOF_BIT])
                o_cause = `MIPE_LCOF_BIT;
            else
                o_any = 1'h0;
        end
    end
endmodule

/* logic/mipe_top.v */
// Contract
// - cause i is bit i in both vectors
// - trap needs privilege/enable, pending&enable, undelegated
// - re-evaluate trap every cycle
// - machine interrupts beat lower-level ones
// - writing zero clears writable pending bits
// - enables writable if source exists, else zero
// - machine external pending follows controller only
// - machine timer pending follows timer compare
// - machine soft pending follows memory-mapped register
// - soft pending/enable may be fixed zero
// - no supervisor mode: supervisor bits read zero
// - supervisor external pending writable by software
// - supervisor external reads software bit OR request
// - CSR updates only stored supervisor external bit
// - supervisor timer pending writable
// - supervisor soft writable, controller may set
// - overflow pending read-write, set by overflow flags
// - priority MEI MSI MTI SEI SSI STI LCOF
// - supervisor views show delegated bits only
// - non-maskable interrupt never in pending vector
// - platform causes ranked highest
// - delegated interrupt masked in machine mode
// - delegation uses pending vector bit layout
`timescale 1ns/1ps
`include "mipe_defines.vh"
module mipe_top #(
    parameter HAS_SMODE = 1,
    parameter HAS_MSOFT = 1,
    parameter HAS_LCOF  = 1,
    parameter HAS_DELEG = 1,
    parameter [`MIPE_XLEN-1:0] PLAT_MASK = 64'hFFFFFFFFFFFF0000
) (
    // Clock and reset
    input  wire                     i_sys_clk,
    input  wire                     i_rst_n,
    // CSR access from the hart
    input  wire [`MIPE_OP_W-1:0]    i_csr_op,
    input  wire [`MIPE_SEL_W-1:0]   i_csr_sel,
    input  wire [`MIPE_XLEN-1:0]    i_csr_wdata,
    output reg  [`MIPE_XLEN-1:0]    o_csr_rdata,
    // Hart state
    input  wire [`MIPE_PRIV_W-1:0]  i_priv,
    input  wire                     i_mstatus_mie,
    input  wire [`MIPE_XLEN-1:0]    i_deleg,
    // Interrupt sources
    input  wire                     i_machine_external_req,
    input  wire                     i_supervisor_external_req,
    input  wire                     i_supervisor_soft_set,
    input  wire                     i_machine_timer_req,
    input  wire                     i_machine_soft_req,
    input  wire [`MIPE_XLEN-1:0]    i_event_counter_overflow_flag,
    input  wire [`MIPE_XLEN-1:0]    i_plat_req,
    // Trap request
    output reg                      o_trap_req,
    output reg  [`MIPE_CAUSE_W-1:0] o_trap_cause
);

// ---------------------------------------------------------------
// Writability masks
// ---------------------------------------------------------------
    localparam [`MIPE_XLEN-1:0] ONE = 64'h0000000000000001;
    localparam [`MIPE_XLEN-1:0] S_BITS = (ONE << `MIPE_SEI_BIT) | (ONE << `MIPE_STI_BIT) |
                                         (ONE << `MIPE_SSI_BIT);
    localparam [`MIPE_XLEN-1:0] M_BITS = (ONE << `MIPE_MEI_BIT) | (ONE << `MIPE_MTI_BIT);
    localparam [`MIPE_XLEN-1:0] MS_BIT = ONE << `MIPE_MSI_BIT;
    localparam [`MIPE_XLEN-1:0] LC_BIT = ONE << `MIPE_LCOF_BIT;
    // Pending bits software may store
    localparam [`MIPE_XLEN-1:0] PEND_WR = (HAS_SMODE ? S_BITS : `MIPE_RST_VEC) |
                                          (HAS_LCOF ? LC_BIT : `MIPE_RST_VEC);
    // Enable bits for every source that can become pending
    localparam [`MIPE_XLEN-1:0] ENAB_WR = PEND_WR | M_BITS | PLAT_MASK |
                                          (HAS_MSOFT ? MS_BIT : `MIPE_RST_VEC);
    localparam [`MIPE_XLEN-1:0] DELEG_OK = HAS_SMODE ? (S_BITS | LC_BIT) : `MIPE_RST_VEC;

// ---------------------------------------------------------------
// Stored state
// ---------------------------------------------------------------
    reg  [`MIPE_XLEN-1:0] pend_sw_ff;
    reg  [`MIPE_XLEN-1:0] enab_ff;
    wire [`MIPE_XLEN-1:0] nxt_pend_csr;
    wire [`MIPE_XLEN-1:0] nxt_enab;
    reg  [`MIPE_XLEN-1:0] nxt_pend_sw;
    reg  [`MIPE_XLEN-1:0] pend_view;
    reg  [`MIPE_XLEN-1:0] hw_pend;
    wire [`MIPE_XLEN-1:0] deleg_eff;
    reg  [`MIPE_XLEN-1:0] pend_mask;
    reg  [`MIPE_XLEN-1:0] enab_mask;
    reg  [`MIPE_XLEN-1:0] nxt_rdata;
    wire [`MIPE_XLEN-1:0] m_ready;
    wire                  m_any;
    wire [`MIPE_CAUSE_W-1:0] m_cause;
    wire                  glob_ok;

    assign deleg_eff = HAS_DELEG ? (i_deleg & DELEG_OK) : `MIPE_RST_VEC;

// ---------------------------------------------------------------
// Pending vector composition
// ---------------------------------------------------------------
    always @* begin
        hw_pend = `MIPE_RST_VEC;
        // Read-only bits follow their sources; no NMI bit exists
        hw_pend[`MIPE_MEI_BIT] = i_machine_external_req;
        hw_pend[`MIPE_MTI_BIT] = i_machine_timer_req;
        hw_pend[`MIPE_MSI_BIT] = HAS_MSOFT ? i_machine_soft_req : 1'h0;
        hw_pend = hw_pend | (i_plat_req & PLAT_MASK);
        pend_view = hw_pend | pend_sw_ff;
        if (HAS_SMODE)
            pend_view[`MIPE_SEI_BIT] = pend_sw_ff[`MIPE_SEI_BIT] | i_supervisor_external_req;
    end

// ---------------------------------------------------------------
// CSR access masks (supervisor views restricted to delegation)
// ---------------------------------------------------------------
    always @* begin
        pend_mask = `MIPE_RST_VEC;
        enab_mask = `MIPE_RST_VEC;
        case (i_csr_sel)
            `MIPE_SEL_PEND:  pend_mask = PEND_WR;
            `MIPE_SEL_ENAB:  enab_mask = ENAB_WR;
            `MIPE_SEL_SPEND: pend_mask = PEND_WR & deleg_eff;
            `MIPE_SEL_SENAB: enab_mask = ENAB_WR & deleg_eff;
            default: begin
                pend_mask = `MIPE_RST_VEC;
                enab_mask = `MIPE_RST_VEC;
            end
        endcase
    end

    // Old value is the stored bit, never the controller signal
    mipe_csr_op u_pend_op (
        .i_op    (i_csr_op),
        .i_old   (pend_sw_ff),
        .i_wdata (i_csr_wdata),
        .i_mask  (pend_mask),
        .o_new   (nxt_pend_csr)
    );

    mipe_csr_op u_enab_op (
        .i_op    (i_csr_op),
        .i_old   (enab_ff),
        .i_wdata (i_csr_wdata),
        .i_mask  (enab_mask),
        .o_new   (nxt_enab)
    );

// ---------------------------------------------------------------
// Stored pending update; hardware sets win over clears
// ---------------------------------------------------------------
    always @* begin
        nxt_pend_sw = nxt_pend_csr;
        if (HAS_SMODE && i_supervisor_soft_set)
            nxt_pend_sw[`MIPE_SSI_BIT] = 1'h1;
        if (HAS_LCOF && (|i_event_counter_overflow_flag))
            nxt_pend_sw[`MIPE_LCOF_BIT] = 1'h1;
    end

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_sw_ff <= `MIPE_RST_VEC;
            enab_ff    <= `MIPE_RST_VEC;
        end else begin
            pend_sw_ff <= nxt_pend_sw & PEND_WR;
            enab_ff    <= nxt_enab & ENAB_WR;
        end
    end

// ---------------------------------------------------------------
// Read data
// ---------------------------------------------------------------
    always @* begin
        case (i_csr_sel)
            `MIPE_SEL_PEND:  nxt_rdata = pend_view;
            `MIPE_SEL_ENAB:  nxt_rdata = enab_ff;
            `MIPE_SEL_SPEND: nxt_rdata = pend_view & deleg_eff;
            `MIPE_SEL_SENAB: nxt_rdata = enab_ff & deleg_eff;
            default:         nxt_rdata = `MIPE_RST_VEC;
        endcase
    end

// ---------------------------------------------------------------
// Machine trap condition
// ---------------------------------------------------------------
    assign glob_ok = (i_priv != `MIPE_PRIV_M) | i_mstatus_mie;
    // Delegated causes never trap to machine level here
    assign m_ready = glob_ok ? (pend_view & enab_ff & ~deleg_eff) : `MIPE_RST_VEC;

    mipe_prio u_prio (
        .i_req   (m_ready),
        .o_any   (m_any),
        .o_cause (m_cause)
    );

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trap_req   <= 1'h0;
            o_trap_cause <= `MIPE_RST_CAUSE;
            o_csr_rdata  <= `MIPE_RST_VEC;
        end else begin
            o_trap_req   <= m_any;
            o_trap_cause <= m_cause;
            o_csr_rdata  <= nxt_rdata;
        end
    end
endmodule

/* dv/mipe_top_props.sv */
`timescale 1ns/1ps
module mipe_top_props #(
    parameter [63:0] PLAT_MASK = 64'hFFFFFFFFFFFF0000
) (
    input wire        i_sys_clk,
    input wire        i_rst_n,
    input wire [1:0]  i_csr_op,
    input wire [1:0]  i_csr_sel,
    input wire [63:0] i_csr_wdata,
    input wire [63:0] o_csr_rdata,
    input wire [1:0]  i_priv,
    input wire        i_mstatus_mie,
    input wire [63:0] i_deleg,
    input wire        i_machine_external_req,
    input wire [63:0] i_plat_req,
    input wire        o_trap_req,
    input wire [5:0]  o_trap_cause
);
    // ---------------------------------------------------------------
    // Shadow of the stored enable vector
    // ---------------------------------------------------------------
    wire [63:0] dmask = i_deleg & 64'h0000000000002222;
    wire [63:0] wmask = (i_csr_sel == 2'h1) ? (PLAT_MASK | 64'h0000000000002AAA) :
                        (i_csr_sel == 2'h3) ? dmask : 64'h0000000000000000;
    wire        gate  = (i_priv != 2'h3) || i_mstatus_mie;
    reg  [63:0] en_ff;
    reg  [63:0] nxt_en;
    reg  [63:0] en_q_ff;
    reg  [63:0] dm_q_ff;
    always @* begin
        case (i_csr_op)
            2'h1:    nxt_en = (en_ff & ~wmask) | (i_csr_wdata & wmask);
            2'h2:    nxt_en = en_ff | (i_csr_wdata & wmask);
            2'h3:    nxt_en = en_ff & ~(i_csr_wdata & wmask);
            default: nxt_en = en_ff;
        endcase
    end
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_ff <= 64'h0000000000000000;
            en_q_ff <= 64'h0000000000000000;
            dm_q_ff <= 64'h0000000000000000;
        end else begin
            en_ff <= nxt_en;
            en_q_ff <= en_ff;
            dm_q_ff <= dmask;
        end
    end
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_mei_ready;
        gate && i_machine_external_req && en_ff[11] && ((i_plat_req & PLAT_MASK & en_ff) == 64'h0);
    endsequence
    sequence s_mei_taken;
        o_trap_req && (o_trap_cause == 6'h0B);
    endsequence
    property p_mei_first; s_mei_ready |=> s_mei_taken; endproperty
    property p_gate; (i_priv == 2'h3) && !i_mstatus_mie |=> !o_trap_req; endproperty
    property p_idle; !o_trap_req |-> (o_trap_cause == 6'h00); endproperty
    property p_cause_en; o_trap_req |-> en_q_ff[o_trap_cause]; endproperty
    property p_deleg; o_trap_req |-> !dm_q_ff[o_trap_cause]; endproperty
    property p_en_read; (i_csr_sel == 2'h1) |=> (o_csr_rdata == en_q_ff); endproperty
    property p_sview; (i_csr_sel == 2'h3) |=> (o_csr_rdata == (en_q_ff & dm_q_ff)); endproperty
    property p_mei_read; (i_csr_sel == 2'h0) |=> (o_csr_rdata[11] == $past(i_machine_external_req)); endproperty
    property p_plat_read;
        (i_csr_sel == 2'h0) |=> (o_csr_rdata[63:16] == ($past(i_plat_req[63:16]) & PLAT_MASK[63:16]));
    endproperty
    a_mei_first: assert property (p_mei_first) else $error("external not first");
    a_gate: assert property (p_gate) else $error("trap while globally disabled");
    a_idle: assert property (p_idle) else $error("cause without trap");
    a_cause_en: assert property (p_cause_en) else $error("trap on disabled cause");
    a_deleg: assert property (p_deleg) else $error("trap on delegated cause");
    a_en_read: assert property (p_en_read) else $error("enable readback wrong");
    a_sview: assert property (p_sview) else $error("supervisor enable view wrong");
    a_mei_read: assert property (p_mei_read) else $error("external pending readback wrong");
    a_plat_read: assert property (p_plat_read) else $error("platform pending readback wrong");
endmodule
bind mipe_top mipe_top_props #(.PLAT_MASK(PLAT_MASK)) mipe_top_props_i (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_csr_op(i_csr_op), .i_csr_sel(i_csr_sel), .i_csr_wdata(i_csr_wdata),
    .o_csr_rdata(o_csr_rdata), .i_priv(i_priv), .i_mstatus_mie(i_mstatus_mie), .i_deleg(i_deleg),
    .i_machine_external_req(i_machine_external_req), .i_plat_req(i_plat_req),
    .o_trap_req(o_trap_req), .o_trap_cause(o_trap_cause));

/* dv/mipe_partner.sv */
`timescale 1ns/1ps
module mipe_partner (
    // Clock
    input  wire        i_sys_clk,
    // Sources
    output reg         o_mei,
    output reg         o_sei,
    output reg         o_sset,
    output reg         o_mti,
    output reg         o_msi,
    output reg  [63:0] o_ovf,
    output reg  [63:0] o_plat
);
    initial begin
        {o_mei, o_sei, o_sset, o_mti, o_msi, o_ovf, o_plat} = 0;
    end
    // Lines: 0 ext, 1 sup ext, 2 sup soft set, 3 timer, 4 soft, 5 overflow
    task drive(input [5:0] lines, input [63:0] plat);
        begin
            @(posedge i_sys_clk);
            #1;
            o_mei = lines[0];
            o_sei = lines[1];
            o_sset = lines[2];
            o_mti = lines[3];
            o_msi = lines[4];
            o_ovf = {58'h0, lines[5], 5'h00};
            o_plat = plat;
        end
    endtask
endmodule

/* dv/mipe_top_tb_top.sv */
`timescale 1ns/1ps
module mipe_top_tb_top;
    reg         i_sys_clk;
    reg         i_rst_n;
    reg  [1:0]  i_csr_op;
    reg  [1:0]  i_csr_sel;
    reg  [63:0] i_csr_wdata;
    reg  [1:0]  i_priv;
    reg         i_mstatus_mie;
    reg  [63:0] i_deleg;
    wire [63:0] o_csr_rdata;
    wire        o_trap_req;
    wire [5:0]  o_trap_cause;
    wire        mei, sei, sset, mti, msi;
    wire [63:0] ovf, plat;
    integer     bad_count, comparisons, cycles, k;
    localparam [47:0] ORDER = {6'h0D, 6'h05, 6'h01, 6'h09, 6'h07, 6'h03, 6'h0B, 6'h10};
    localparam [63:0] ONES = 64'hFFFFFFFFFFFFFFFF;
    mipe_top mipe_top_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_csr_op(i_csr_op),
        .i_csr_sel(i_csr_sel), .i_csr_wdata(i_csr_wdata), .o_csr_rdata(o_csr_rdata), .i_priv(i_priv),
        .i_mstatus_mie(i_mstatus_mie), .i_deleg(i_deleg), .i_machine_external_req(mei),
        .i_supervisor_external_req(sei), .i_supervisor_soft_set(sset), .i_machine_timer_req(mti),
        .i_machine_soft_req(msi), .i_event_counter_overflow_flag(ovf), .i_plat_req(plat),
        .o_trap_req(o_trap_req), .o_trap_cause(o_trap_cause));
    mipe_partner mipe_partner_i (.i_sys_clk(i_sys_clk), .o_mei(mei), .o_sei(sei), .o_sset(sset),
        .o_mti(mti), .o_msi(msi), .o_ovf(ovf), .o_plat(plat));
    always #20 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    task check(input [127:0] what, input [63:0] seen, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task csr(input [1:0] op, input [1:0] sel, input [63:0] wd);
        begin
            @(posedge i_sys_clk);
            #1;
            i_csr_op = op;
            i_csr_sel = sel;
            i_csr_wdata = wd;
            @(posedge i_sys_clk);
            #1;
            i_csr_op = 2'h0;
        end
    endtask
    task rd(input [1:0] sel, input [63:0] exp);
        begin
            csr(2'h0, sel, 64'h0);
            check("csr_rdata", o_csr_rdata, exp);
        end
    endtask
    task hart(input [1:0] priv, input mie, input [63:0] deleg);
        begin
            @(posedge i_sys_clk);
            #1;
            i_priv = priv;
            i_mstatus_mie = mie;
            i_deleg = deleg;
        end
    endtask
    task trap(input req, input [5:0] cause);
        begin
            repeat (2) @(posedge i_sys_clk);
            #1;
            check("trap_req", {63'h0, o_trap_req}, {63'h0, req});
            check("trap_cause", {58'h0, o_trap_cause}, {58'h0, cause});
        end
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_access;
        begin
            rd(2'h0, 64'h0);
            rd(2'h1, 64'h0);
            csr(2'h1, 2'h1, ONES);
            rd(2'h1, 64'hFFFFFFFFFFFF2AAA);
            csr(2'h3, 2'h1, 64'h800);
            rd(2'h1, 64'hFFFFFFFFFFFF22AA);
            csr(2'h2, 2'h1, 64'h800);
            csr(2'h1, 2'h0, ONES);
            rd(2'h0, 64'h2222);
            csr(2'h1, 2'h0, 64'h0);
            rd(2'h0, 64'h0);
            mipe_partner_i.drive(6'h02, 64'h0);
            csr(2'h2, 2'h0, 64'h0);
            rd(2'h0, 64'h200);
            mipe_partner_i.drive(6'h00, 64'h0);
            rd(2'h0, 64'h0);
            mipe_partner_i.drive(6'h04, 64'h0);
            mipe_partner_i.drive(6'h20, 64'h0);
            mipe_partner_i.drive(6'h00, 64'h0);
            rd(2'h0, 64'h2002);
            mipe_partner_i.drive(6'h19, 64'h10000);
            csr(2'h1, 2'h0, 64'h0);
            rd(2'h0, 64'h10888);
        end
    endtask
    task t_priority;
        begin
            csr(2'h1, 2'h0, 64'h2222);
            hart(2'h0, 1'b0, 64'h0);
            for (k = 0; k < 8; k = k + 1) begin
                trap(1'b1, ORDER[k*6 +: 6]);
                csr(2'h3, 2'h1, 64'h1 << ORDER[k*6 +: 6]);
            end
            trap(1'b0, 6'h00);
        end
    endtask
    task t_gate;
        begin
            csr(2'h2, 2'h1, 64'h800);
            hart(2'h3, 1'b0, 64'h0);
            trap(1'b0, 6'h00);
            hart(2'h3, 1'b1, 64'h0);
            trap(1'b1, 6'h0B);
            csr(2'h1, 2'h1, 64'h20);
            trap(1'b1, 6'h05);
            hart(2'h3, 1'b1, 64'h20);
            trap(1'b0, 6'h00);
            rd(2'h2, 64'h20);
            rd(2'h3, 64'h20);
        end
    endtask
    task t_reset;
        begin
            @(posedge i_sys_clk);
            #1;
            i_rst_n = 1'b0;
            @(posedge i_sys_clk);
            #1;
            i_rst_n = 1'b1;
            rd(2'h1, 64'h0);
            trap(1'b0, 6'h00);
            rd(2'h0, 64'h10888);
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d bad_count %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        {i_sys_clk, i_rst_n, i_csr_op, i_csr_sel, i_csr_wdata} = 0;
        {i_priv, i_mstatus_mie, i_deleg} = {2'h3, 65'h0};
        {bad_count, comparisons, cycles} = 0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rst_n = 1'b1;
        t_access;
        t_priority;
        t_gate;
        t_reset;
        final_report;
    end
endmodule
